// ===== core/ficp_indirect_port.v
// AXI4-Lite register slave giving indirect access to the switch fabric register bus
`timescale 1ns/100ps
`include "ficp_regs.vh"
// Overview of operation
// - Data register holds transfer value, resets zero
// - Transfer targets index field of command
// - Data read: fetched value or last written
// - Writing pending one launches transfer
// - Pending stays high until completion
// - Fabric completion clears pending, data already valid
// - Bit 30 selects direction, one is read
// - Step-up data write launches, then increments
// - Step-up data read increments, launches fetch
// - Step-down data write launches, then decrements
// - Step-down data read decrements, launches fetch
// - Step-up wins over step-down
// - Lane mask gates written bytes
// - Bits 15:0 hold target index
module ficp_indirect_port (
	input wire clk, // System clock, 25 MHz
	input wire arst_n, // Asynchronous reset, active low
	input wire [11:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output wire s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write strobes
	input wire s_axi_wvalid, // Write data valid
	output wire s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [11:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output wire s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	output wire fab_req, // Fabric request, held until ack
	output wire fab_we, // Fabric write qualifier
	output wire [15:0] fab_addr, // Fabric register index
	output wire [3:0] fab_be, // Fabric byte enables
	output wire [31:0] fab_wdata, // Fabric write value
	input wire fab_ack, // Fabric completion pulse
	input wire [31:0] fab_rdata // Fabric read value
);
	// Command fields
	reg pending_reg; // Transfer in flight
	reg dir_reg; // direction_select, 1 = read
	reg step_up_reg; // Step-up enable
	reg step_down_reg; // step_down_enable
	reg [3:0] mask_reg; // lane_write_mask
	reg [15:0] index_reg; // target_register_index
	reg [31:0] wval_reg; // Value last written by host
	reg [1:0] step_reg; // Post-write step: 01 up, 10 down
	// Write channel capture
	reg aw_held_reg; // Write address taken
	reg w_held_reg; // Write data taken
	reg [11:0] awaddr_reg; // Held write address
	reg [31:0] wdata_reg; // Held write data
	reg [3:0] wstrb_reg; // Held write strobes
	reg start_reg; // One-cycle launch pulse
	wire done; // Fabric transfer finished
	wire [31:0] fetched; // Last fetched fabric value
	wire wr_fire; // Both write halves present
	wire rd_fire; // Read address taken
	wire [31:0] strb_mask; // Strobes expanded to bits
	wire [31:0] wr_merged; // Data after byte strobes
	wire [31:0] cmd_view; // Command register as read
	wire [31:0] data_view; // Data register as read

	// Each channel is taken at most once until the response is accepted
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

	// Reserved bits 27:20 read as zero
	assign cmd_view = {pending_reg, dir_reg, step_up_reg, step_down_reg, 8'h00, mask_reg, index_reg};
	// Read direction shows the fetched value, write direction the host value
	assign data_view = dir_reg ? fetched : wval_reg;

	// Write channel capture, either order
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			// Both halves consumed when the response goes out
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
		end
	end

	// Write response
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FICP_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			// Unmapped addresses answer with slave error
			if (awaddr_reg[11:2] == `FICP_DATA_OFFSET >> 2 || awaddr_reg[11:2] == `FICP_CMD_OFFSET >> 2)
				s_axi_bresp <= `FICP_RESP_OKAY;
			else
				s_axi_bresp <= `FICP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read response
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `FICP_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `FICP_RESP_OKAY;
			if (s_axi_araddr[11:2] == `FICP_DATA_OFFSET >> 2) begin
				s_axi_rdata <= data_view;
			end else if (s_axi_araddr[11:2] == `FICP_CMD_OFFSET >> 2) begin
				s_axi_rdata <= cmd_view;
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `FICP_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	assign wr_merged = (wval_reg & ~strb_mask) | (wdata_reg & strb_mask);

	// Command and data register state; host write to a busy port is still stored
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pending_reg <= 1'b0;
			dir_reg <= 1'b0;
			step_up_reg <= 1'b0;
			step_down_reg <= 1'b0;
			mask_reg <= 4'h0;
			index_reg <= 16'h0000;
			wval_reg <= `FICP_DATA_RESET;
			step_reg <= 2'b00;
			start_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			// Completion clears pending; fetched data is already latched here
			if (done) begin
				pending_reg <= 1'b0;
				// Write stepping happens only after the write finishes
				if (step_reg == 2'b01)
					index_reg <= index_reg + 16'h0001;
				else if (step_reg == 2'b10)
					index_reg <= index_reg - 16'h0001;
				step_reg <= 2'b00;
			end
			if (wr_fire && awaddr_reg[11:2] == `FICP_CMD_OFFSET >> 2) begin
				if (wstrb_reg[3]) begin
					dir_reg <= wdata_reg[`FICP_DIR_BIT];
					step_up_reg <= wdata_reg[`FICP_STEP_UP_BIT];
					step_down_reg <= wdata_reg[`FICP_STEP_DOWN_BIT];
					// Only a one launches; a zero leaves a running transfer alone
					if (wdata_reg[`FICP_PENDING_BIT] && !pending_reg) begin
						pending_reg <= 1'b1;
						start_reg <= 1'b1;
						step_reg <= 2'b00;
					end
				end
				if (wstrb_reg[2])
					mask_reg <= wdata_reg[`FICP_MASK_HI:`FICP_MASK_LO];
				if (wstrb_reg[1])
					index_reg[15:8] <= wdata_reg[15:8];
				if (wstrb_reg[0])
					index_reg[7:0] <= wdata_reg[7:0];
			end
			if (wr_fire && awaddr_reg[11:2] == `FICP_DATA_OFFSET >> 2) begin
				wval_reg <= wr_merged;
				// Stepping write launches automatically; up takes precedence
				if ((step_up_reg || step_down_reg) && !pending_reg) begin
					pending_reg <= 1'b1;
					start_reg <= 1'b1;
					step_reg <= step_up_reg ? 2'b01 : 2'b10;
				end
			end
			// Stepping read moves the index first, then fetches the next one
			if (rd_fire && s_axi_araddr[11:2] == `FICP_DATA_OFFSET >> 2 && dir_reg && !pending_reg) begin
				if (step_up_reg) begin
					index_reg <= index_reg + 16'h0001;
					pending_reg <= 1'b1;
					start_reg <= 1'b1;
				end else if (step_down_reg) begin
					index_reg <= index_reg - 16'h0001;
					pending_reg <= 1'b1;
					start_reg <= 1'b1;
				end
			end
		end
	end

	// Fabric engine samples index one cycle after launch, so stepped index is used
	ficp_fabric_master u_master (
		.clk(clk),
		.arst_n(arst_n),
		.start(start_reg),
		.dir_read(dir_reg),
		.index(index_reg),
		.mask(mask_reg),
		.wdata(wval_reg),
		.fab_req(fab_req),
		.fab_we(fab_we),
		.fab_addr(fab_addr),
		.fab_be(fab_be),
		.fab_wdata(fab_wdata),
		.fab_ack(fab_ack),
		.fab_rdata(fab_rdata),
		.done(done),
		.rdata(fetched)
	);
endmodule

// ===== core/ficp_regs.vh
// Register offsets, field positions and reset values of the indirect fabric access port
`ifndef FICP_REGS_VH
`define FICP_REGS_VH
`define FICP_DATA_OFFSET 12'h1ac
`define FICP_CMD_OFFSET 12'h1b0
`define FICP_DATA_RESET 32'h00000000
`define FICP_CMD_RESET 32'h00000000
`define FICP_PENDING_BIT 31
`define FICP_DIR_BIT 30
`define FICP_STEP_UP_BIT 29
`define FICP_STEP_DOWN_BIT 28
`define FICP_MASK_HI 19
`define FICP_MASK_LO 16
`define FICP_INDEX_HI 15
`define FICP_INDEX_LO 0
`define FICP_RESP_OKAY 2'b00
`define FICP_RESP_SLVERR 2'b10
`endif

// ===== core/ficp_fabric_master.v
// Fabric-side transfer engine: one request, waits for the fabric to acknowledge
`timescale 1ns/100ps
module ficp_fabric_master (
	input wire clk, // System clock
	input wire arst_n, // Asynchronous reset, active low
	input wire start, // One-cycle launch pulse
	input wire dir_read, // 1 = read, 0 = write
	input wire [15:0] index, // Target register index
	input wire [3:0] mask, // Byte lane write mask
	input wire [31:0] wdata, // Value to write
	output reg fab_req, // Request to fabric, held until ack
	output reg fab_we, // Write strobe qualifier
	output reg [15:0] fab_addr, // Fabric register index
	output reg [3:0] fab_be, // Byte enables
	output reg [31:0] fab_wdata, // Write value
	input wire fab_ack, // Fabric completion, same clock
	input wire [31:0] fab_rdata, // Read value, valid with ack
	output reg done, // One-cycle completion pulse
	output reg [31:0] rdata // Captured read value
);
	// Request is held until the fabric answers; start is ignored while busy
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fab_req <= 1'b0;
			fab_we <= 1'b0;
			fab_addr <= 16'h0000;
			fab_be <= 4'h0;
			fab_wdata <= 32'h00000000;
			done <= 1'b0;
			rdata <= 32'h00000000;
		end else begin
			done <= 1'b0;
			if (fab_req) begin
				if (fab_ack) begin
					fab_req <= 1'b0;
					done <= 1'b1;
					// Capture read value in the same edge as done
					if (!fab_we)
						rdata <= fab_rdata;
				end
			end else if (start) begin
				fab_req <= 1'b1;
				fab_we <= !dir_read;
				fab_addr <= index;
				// Unselected lanes are left untouched by the fabric
				fab_be <= dir_read ? 4'h0 : mask;
				fab_wdata <= wdata;
			end
		end
	end
endmodule

// ===== sim/ficp_fabric_model.sv
// Behavioural fabric register bank on the far side of the port
`timescale 1ns/100ps
module ficp_fabric_model (
	input wire clk, // System clock
	input wire arst_n, // Reset, active low
	input wire fab_req, // Request, held until ack
	input wire fab_we, // 1 = write
	input wire [15:0] fab_addr, // Register index
	input wire [3:0] fab_be, // Byte lanes
	input wire [31:0] fab_wdata, // Write value
	input wire [1:0] lag, // Extra wait cycles
	output logic fab_ack, // Completion pulse
	output logic [31:0] fab_rdata // Read value with ack
);
	logic [31:0] mem [256]; // Bank, seed mirrored in bench
	logic [1:0] cnt; // Wait counter
	initial for (int i = 0; i < 256; i++) mem[i] = i * 32'h01010101;
	// Ack after lag cycles; rdata inverted outside ack so stale data never passes
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fab_ack <= 0;
			cnt <= 0;
			fab_rdata <= 32'h5a5a5a5a;
		end else if (fab_req && !fab_ack && cnt >= lag) begin
			fab_ack <= 1;
			cnt <= 0;
			fab_rdata <= mem[fab_addr[7:0]];
			for (int b = 0; b < 4; b++)
				if (fab_we && fab_be[b]) mem[fab_addr[7:0]][8*b+:8] <= fab_wdata[8*b+:8];
		end else begin
			fab_ack <= 0;
			cnt <= (fab_req && !fab_ack) ? cnt + 2'h1 : 2'h0;
			fab_rdata <= ~fab_rdata;
		end
	end
endmodule

// ===== sim/ficp_indirect_port_checker.sv
// Concurrent checks on the indirect port's host and fabric ports
`timescale 1ns/100ps
module ficp_indirect_port_checker (
	input wire clk, arst_n, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready, // Host write side
	input wire [1:0] s_axi_bresp, // Write response
	input wire s_axi_arready, s_axi_rvalid, s_axi_rready, // Host read side
	input wire [31:0] s_axi_rdata, fab_wdata, // Data paths
	input wire fab_req, fab_we, fab_ack, // Fabric handshake
	input wire [15:0] fab_addr, // Fabric index
	input wire [3:0] fab_be // Fabric lanes
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_hold; fab_req && !fab_ack |=> fab_req && $stable({fab_we, fab_addr, fab_be, fab_wdata}); endproperty
	a_hold: assert property (p_hold) else $error("fabric request changed before ack");
	property p_end; fab_req && fab_ack |=> !fab_req; endproperty
	a_end: assert property (p_end) else $error("fabric request outlived ack");
	property p_rdbe; fab_req && !fab_we |-> fab_be == 4'h0; endproperty
	a_rdbe: assert property (p_rdbe) else $error("read carried lanes");
	property p_go; $rose(fab_req) |-> $past(s_axi_bvalid) || $past(s_axi_rvalid); endproperty
	a_go: assert property (p_go) else $error("transfer without host access");
	property p_bv; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bv: assert property (p_bv) else $error("write response dropped");
	property p_bgate; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_bgate: assert property (p_bgate) else $error("write taken during response");
	property p_rv; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rv: assert property (p_rv) else $error("read data dropped");
	property p_rgate; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rgate: assert property (p_rgate) else $error("read taken during response");
	c_wr: cover property (fab_req && fab_we && fab_ack);
	c_rd: cover property (fab_req && !fab_we && fab_ack);
	c_slow: cover property (fab_req && !fab_ack ##1 fab_req && !fab_ack);
endmodule
bind ficp_indirect_port ficp_indirect_port_checker chk_u (.clk, .arst_n, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.fab_wdata, .fab_req, .fab_we, .fab_ack, .fab_addr, .fab_be);

// ===== sim/ficp_indirect_port_tb.sv
// Self-checking bench for the indirect fabric access port
`timescale 1ns/100ps
module ficp_indirect_port_tb;
	localparam logic [11:0] DA = 12'h1ac; // Data register
	localparam logic [11:0] CM = 12'h1b0; // Command register
	logic clk = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, fab_req, fab_we, fab_ack;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0; // Host addresses
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, fab_wdata, fab_rdata, v, w, ec; // Data, scratch, expected command
	logic [3:0] s_axi_wstrb = 0, fab_be; // Lanes
	logic [1:0] s_axi_bresp, s_axi_rresp, r, lag = 0; // Responses, fabric delay
	logic [15:0] fab_addr, t; // Index
	logic [31:0] rm [256]; // Reference bank
	int n_mismatch = 0, checks = 0, cyc = 0;
	ficp_indirect_port dut_u (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fab_req,
		.fab_we, .fab_addr, .fab_be, .fab_wdata, .fab_ack, .fab_rdata);
	ficp_fabric_model fab_u (.clk, .arst_n, .fab_req, .fab_we, .fab_addr, .fab_be, .fab_wdata, .lag, .fab_ack,
		.fab_rdata);
	initial forever #20 clk = ~clk;
	// Hang guard, far above the expected several hundred cycles
	always @(posedge clk) if (++cyc == 30000) begin
		n_mismatch++;
		close_out();
	end
	task automatic chk(input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Write: offer both halves, release each when taken, hold bready until bvalid
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic ta, tw, tb;
		@(posedge clk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(negedge clk);
			{ta, tw, tb, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge clk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
		end while (!tb);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
		logic ta, tb;
		@(posedge clk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do begin
			@(negedge clk);
			{ta, tb, d, rs} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge clk);
			if (ta) s_axi_arvalid <= 0;
		end while (!tb);
		s_axi_rready <= 0;
	endtask
	// Poll until the transfer finishes, then compare the whole command word
	// Nothing but polls reach the port while the transfer is pending
	task automatic idle;
		do rd(CM, v, r); while (v[31] !== 1'b0);
		chk(v, ec);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 256; i++) rm[i] = i * 32'h01010101;
		v = $urandom(89);
		repeat (20) @(posedge clk);
		arst_n <= 1;
		rd(DA, v, r); chk(v, 0);
		rd(CM, v, r); chk(v, 0);
		rd(12'h1b4, v, r); chk(r, 2);
		wr(12'h1b8, 1, r); chk(r, 2);
		wr(CM, 32'h0ff00000 | 16'h33, r); rd(CM, v, r); chk(v, 32'h33);
		$display("test reset and reserved done");
		for (int k = 0; k < 8; k++) begin
			lag <= 2'($urandom);
			t = 16'($urandom % 240 + 8);
			w = $urandom;
			ec = {12'h0, 4'($urandom), t};
			// Write direction first, so the data register shows the host value
			wr(CM, ec, r); chk(r, 0);
			wr(DA, w, r); rd(DA, v, r); chk(v, w);
			wr(CM, ec | 32'h80000000, r); idle;
			for (int b = 0; b < 4; b++) if (ec[16+b]) rm[t][8*b+:8] = w[8*b+:8];
			ec = 32'h40000000 | t;
			wr(CM, ec | 32'h80000000, r); idle;
			rd(DA, v, r); chk(v, rm[t]);
		end
		$display("test plain transfers done");
		for (int s = 1; s < 4; s++) begin
			w = $urandom;
			ec = {2'b00, 2'(s), 12'h00f, t};
			wr(CM, ec, r);
			wr(DA, w, r);
			rm[t] = w;
			t = t + (s > 1 ? 16'h1 : 16'hffff);
			ec[15:0] = t; idle;
			ec = {2'b01, 2'(s), 12'h0, t};
			wr(CM, ec | 32'h80000000, r); idle;
			rd(DA, v, r); chk(v, rm[t]);
			t = t + (s > 1 ? 16'h1 : 16'hffff);
			ec[15:0] = t; idle;
			ec[29:28] = 2'b00;
			wr(CM, ec, r); rd(DA, v, r); chk(v, rm[t]);
		end
		$display("test stepping done");
		close_out();
	end
endmodule
